//--- design/rrc_dev.sv
// Device end: opcode interpreter, result registers, context save.
// Assumes the host sends whole frames and waits while busy is high.
// What this block does
// - Host enters crystal standby before result reads.
// - Memory clock bit makes results readable.
// - Bits 5:4 of 0x924 pick result kind.
// - 24-bit result split across three registers.
// - Host returns to RC standby after reading.
// - Host counts ranging failures, saturating at 3.
// - Device answers ranging exchange without host.
// - Signal strength counts dB above noise threshold.
// - Role responder then overhear on enables overhearing.
// - Irq bit 15 means exchange done when overhearing.
// - Exchange done raised on received response.
// - Address bytes muxed by 0x927 bit 0.
// - RC standby then overhear off disables mode.
// - Regulator opcode, UART inserts 0x01 byte.
// - Regulator defaults linear; 1 switches in crystal standby only.
// - Save-context opcode copies registers to RAM.
// - Host saves context before sleep, keeps RAM.
// - Wake restores only from retained valid image.
// - Duty cycling autosaves; sleep exit clears pointer.
module rrc_dev
	import rrc_pkg::*;
(
	rrc_link_if.dev link, // Command link.
	input wire logic [23:0] meas_result, // Measured ranging result.
	input wire logic [23:0] meas_filtered, // Filtered result.
	input wire logic [7:0] meas_rssi, // Strength in dB above threshold.
	input wire logic [31:0] heard_addr, // Overheard exchange address.
	input wire logic response_heard, // Pulse: responder answer heard.
	input wire logic duty_cycle, // Duty-cycled operation active.
	output logic switcher_on, // High: switching converter in use.
	output logic overhear_active, // Overhearing mode active.
	output logic asleep, // Device in sleep.
	output logic [7:0] rx_payload_ptr // Receive buffer payload pointer.
);
	typedef enum {S_OP, S_A0, S_A1, S_A2, S_SKIP} rrc_dec_e;
	rrc_dec_e state;
	logic [7:0] opcode, a0, a1;
	logic [7:0] out_sel, addr_sel, mem_clk, saved_out, saved_asel;
	logic role_resp, xosc, reg_param, image_valid, ram_kept;
	logic [23:0] res_hold, filt_hold, res_view;
	logic [31:0] addr_hold;
	logic [7:0] rssi_hold;
	logic [11:0] raddr;

	// Register read decode, shared by the response path.
	function automatic logic [7:0] rd(input logic [11:0] a);
		case (a)
			REG_OUT_SEL: rd = out_sel;
			REG_ADDR_SEL: rd = addr_sel;
			REG_MEM_CLK: rd = mem_clk;
			REG_RES_HIGH: rd = mem_clk[MEM_CLK_BIT] ? res_view[23:16] : 8'h00;
			REG_RES_MID: rd = mem_clk[MEM_CLK_BIT] ? res_view[15:8] : 8'h00;
			REG_RES_LOW: rd = mem_clk[MEM_CLK_BIT] ? res_view[7:0] : 8'h00;
			REG_ADDR_EVEN: rd = addr_sel[0] ? addr_hold[23:16] : addr_hold[7:0];
			REG_ADDR_ODD: rd = addr_sel[0] ? addr_hold[31:24] : addr_hold[15:8];
			default: rd = 8'h00;
		endcase
	endfunction

	assign raddr = {a0[3:0], a1};
	// The kind field picks the output at read time, so a kind written
	// after the freeze still takes effect.
	assign res_view = (out_sel[KIND_LSB +: 2] == 2'h1) ? filt_hold :
		res_hold;
	assign link.busy = (state != S_OP);

	// ==========================================================
	// Frame decoder: opcode then argument bytes.
	always_ff @(posedge link.core_clk or posedge link.rst)
	begin
		if (link.rst)
		begin
			state <= S_OP;
			opcode <= 8'h00;
			a0 <= 8'h00;
			a1 <= 8'h00;
		end
		else if (link.cmd_valid)
		begin
			case (state)
				S_OP:
				begin
					opcode <= link.cmd_byte;
					if (link.cmd_last)
						state <= S_OP;
					else if (link.uart_mode && link.cmd_byte == OP_REGULATOR)
						state <= S_SKIP;
					else
						state <= S_A0;
				end
				S_SKIP: state <= S_A0;
				S_A0:
				begin
					a0 <= link.cmd_byte;
					state <= link.cmd_last ? S_OP : S_A1;
				end
				S_A1:
				begin
					a1 <= link.cmd_byte;
					state <= link.cmd_last ? S_OP : S_A2;
				end
				S_A2: state <= link.cmd_last ? S_OP : S_A2;
				default: state <= S_OP;
			endcase
		end
	end

	// ==========================================================
	// Mode commands: role, overhearing, regulator, standby.
	always_ff @(posedge link.core_clk or posedge link.rst)
	begin
		if (link.rst)
		begin
			role_resp <= 1'b0;
			overhear_active <= 1'b0;
			reg_param <= 1'b0;
			xosc <= 1'b0;
		end
		else if (link.cmd_valid && state == S_A0 && link.cmd_last)
		begin
			case (opcode)
				OP_ROLE: role_resp <= (link.cmd_byte == ROLE_RESPONDER);
				OP_OVERHEAR:
				begin
					if (link.cmd_byte == OVERHEAR_ON && role_resp)
						overhear_active <= 1'b1;
					else if (link.cmd_byte == OVERHEAR_OFF && !xosc)
						overhear_active <= 1'b0;
				end
				OP_REGULATOR: reg_param <= link.cmd_byte[0];
				OP_STANDBY: xosc <= (link.cmd_byte == STBY_XOSC);
				default: xosc <= xosc;
			endcase
		end
	end

	// ==========================================================
	// Regulator in use: the linear one in RC standby and in sleep.
	always_ff @(posedge link.core_clk or posedge link.rst)
	begin
		if (link.rst)
			switcher_on <= 1'b0;
		else
			switcher_on <= reg_param && xosc && !asleep;
	end

	// ==========================================================
	// Writable registers, context image and sleep handling.
	always_ff @(posedge link.core_clk or posedge link.rst)
	begin
		if (link.rst)
		begin
			out_sel <= 8'h00;
			addr_sel <= 8'h00;
			mem_clk <= 8'h00;
			saved_out <= 8'h00;
			saved_asel <= 8'h00;
			image_valid <= 1'b0;
			ram_kept <= 1'b0;
			asleep <= 1'b0;
			rx_payload_ptr <= RX_PTR_RESET;
		end
		else if (link.cmd_valid && state == S_OP && asleep)
		begin
			asleep <= 1'b0;
			rx_payload_ptr <= RX_PTR_RESET;
			if (ram_kept && image_valid)
			begin
				out_sel <= saved_out;
				addr_sel <= saved_asel;
			end
		end
		else if (link.cmd_valid && state == S_OP && link.cmd_last &&
			link.cmd_byte == OP_SAVE_CTX)
		begin
			saved_out <= out_sel;
			saved_asel <= addr_sel;
			image_valid <= 1'b1;
		end
		else if (link.cmd_valid && state == S_A0 && link.cmd_last &&
			opcode == OP_SLEEP)
		begin
			asleep <= 1'b1;
			ram_kept <= link.cmd_byte[0];
			out_sel <= 8'h00; // Register contents are lost in sleep.
			addr_sel <= 8'h00;
			mem_clk <= 8'h00;
			if (duty_cycle)
			begin
				saved_out <= out_sel;
				saved_asel <= addr_sel;
				image_valid <= 1'b1;
			end
		end
		else if (link.cmd_valid && state == S_A2 && opcode == OP_WRITE_REG)
		begin
			case (raddr)
				REG_OUT_SEL: out_sel <= link.cmd_byte;
				REG_ADDR_SEL: addr_sel <= link.cmd_byte;
				REG_MEM_CLK: mem_clk <= link.cmd_byte;
				default: mem_clk <= mem_clk;
			endcase
		end
	end

	// ==========================================================
	// Result capture and exchange-done interrupt.
	always_ff @(posedge link.core_clk or posedge link.rst)
	begin
		if (link.rst)
		begin
			res_hold <= 24'h000000;
			filt_hold <= 24'h000000;
			addr_hold <= 32'h00000000;
			rssi_hold <= 8'h00;
			link.irq <= 16'h0000;
			link.ranging_fail <= 1'b0;
		end
		else
		begin
			link.ranging_fail <= link.ranging_start && !response_heard;
			if (response_heard && !mem_clk[MEM_CLK_BIT])
			begin
				res_hold <= meas_result;
				filt_hold <= meas_filtered;
				rssi_hold <= meas_rssi;
				addr_hold <= heard_addr;
			end
			if (response_heard && overhear_active)
				link.irq <= link.irq | IRQ_EXCH_DONE;
			else if (link.cmd_valid && state == S_OP)
				link.irq <= 16'h0000;
		end
	end

	// ==========================================================
	// Read response: register data, or strength at read address 0x000.
	always_ff @(posedge link.core_clk or posedge link.rst)
	begin
		if (link.rst)
		begin
			link.rsp_valid <= 1'b0;
			link.rsp_byte <= 8'h00;
		end
		else
		begin
			link.rsp_valid <= link.cmd_valid && state == S_A2 &&
				opcode == OP_READ_REG;
			link.rsp_byte <= (raddr == 12'h000) ? rssi_hold : rd(raddr);
		end
	end
endmodule

//--- design/rrc_host.sv
// Host end: AHB-Lite slave for software and command sequencer.
// Assumes the device answers reads within a few cycles of the frame.
module rrc_host
	import rrc_pkg::*;
(
	input wire logic hclk, // Clock, same as core_clk.
	input wire logic hresetn, // Unused mirror of reset, active low.
	input wire logic hsel, // Slave select.
	input wire logic [31:0] haddr, // Address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write.
	input wire logic [2:0] hsize, // Size.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready.
	output logic [31:0] hrdata, // Read data.
	output logic hreadyout, // Slave ready.
	output logic hresp, // Response, always OKAY.
	rrc_link_if.host link // Command link.
);
	typedef enum {H_IDLE, H_SEND, H_WAIT, H_READ} rrc_seq_e;
	rrc_seq_e seq;
	logic [2:0] job;
	logic [7:0] arg, last_rd;
	logic uart_sel;
	logic [4:0] step;
	logic [2:0] nbytes, bidx;
	logic [7:0] frame [0:4];
	logic [3:0] errors;
	logic [23:0] result;
	logic [31:0] addr_word;
	logic [7:0] rssi;
	logic ph_write, ph_sel;
	logic [7:0] ph_addr;
	logic job_go;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign link.uart_mode = uart_sel;
	assign link.ranging_start = 1'b0;
	assign job_go = ph_sel && ph_write && ph_addr == HA_CMD && seq == H_IDLE;

	// AHB address phase capture; data phase decodes next cycle.
	always_ff @(posedge hclk or posedge link.rst)
	begin
		if (link.rst)
		begin
			ph_write <= 1'b0;
			ph_sel <= 1'b0;
			ph_addr <= 8'h00;
		end
		else if (hready)
		begin
			ph_sel <= hsel && htrans[1];
			ph_write <= hwrite;
			ph_addr <= haddr[7:0];
		end
	end

	// Software registers: ARG byte, and bit 8 asks for UART framing.
	always_ff @(posedge hclk or posedge link.rst)
	begin
		if (link.rst)
		begin
			arg <= 8'h00;
			uart_sel <= 1'b0;
		end
		else if (ph_sel && ph_write && ph_addr == HA_ARG)
		begin
			arg <= hwdata[7:0];
			uart_sel <= hwdata[8];
		end
	end

	always_comb
	begin
		case (ph_addr)
			HA_STATUS: hrdata = {24'h0, errors, 1'b0, seq != H_IDLE, job[1:0]};
			HA_RESULT: hrdata = {8'h00, result};
			HA_ADDR: hrdata = addr_word;
			HA_RSSI: hrdata = {24'h0, rssi};
			HA_ARG: hrdata = {23'h0, uart_sel, arg};
			default: hrdata = 32'h00000000;
		endcase
	end

	// Sequencer: each job is a list of frames sent in order.
	always_ff @(posedge hclk or posedge link.rst)
	begin
		if (link.rst)
		begin
			seq <= H_IDLE;
			job <= 3'h0;
			step <= 5'h00;
			bidx <= 3'h0;
			nbytes <= 3'h0;
			errors <= 4'h0;
			result <= 24'h0;
			addr_word <= 32'h0;
			rssi <= 8'h00;
			last_rd <= 8'h00;
			for (int i = 0; i < 5; i++)
				frame[i] <= 8'h00;
		end
		else
		begin
			if (link.ranging_fail && errors != MAX_ERRORS)
				errors <= errors + 4'h1;
			case (seq)
				H_IDLE:
					if (job_go)
					begin
						job <= hwdata[2:0];
						step <= 5'h00;
						seq <= H_WAIT;
					end
				H_WAIT:
					if (!link.busy)
					begin
						// Build the next frame of the job.
						seq <= H_SEND;
						bidx <= 3'h0;
						step <= step + 5'h01;
						nbytes <= 3'h2;
						frame[0] <= OP_STANDBY;
						frame[1] <= STBY_RC;
						frame[2] <= 8'h00;
						frame[3] <= 8'h00;
						frame[4] <= 8'h00;
						case (job)
						JOB_READ:
							case (step)
							5'd0: frame[1] <= STBY_XOSC;
							5'd1: {nbytes, frame[0], frame[1], frame[2], frame[3]}
								<= {3'h4, OP_WRITE_REG, 8'h09, 8'h7f,
								last_rd | 8'h02};
							5'd2, 5'd3, 5'd4, 5'd5, 5'd6, 5'd7, 5'd8, 5'd9:
							begin
								nbytes <= 3'h4;
								frame[0] <= OP_READ_REG;
								frame[1] <= 8'h09;
								case (step)
								5'd2: frame[2] <= 8'h24;
								5'd3: {frame[0], frame[2], frame[3]} <= {OP_WRITE_REG,
									8'h24, (last_rd & MASK_KIND) |
									{2'h0, arg[1:0] & KIND_FIELD, 4'h0}};
								5'd4: frame[2] <= 8'h61;
								5'd5: frame[2] <= 8'h62;
								5'd6: frame[2] <= 8'h63;
								5'd7: {frame[0], frame[2], frame[3]} <= {OP_WRITE_REG,
									8'h27, 8'h00};
								5'd8: frame[2] <= 8'h60;
								default: frame[2] <= 8'h5f;
								endcase
							end
							5'd10: {nbytes, frame[0], frame[1], frame[2], frame[3]}
								<= {3'h4, OP_WRITE_REG, 8'h09, 8'h27, 8'h01};
							5'd11: {nbytes, frame[0], frame[1], frame[2]}
								<= {3'h4, OP_READ_REG, 8'h09, 8'h60};
							5'd12: {nbytes, frame[0], frame[1], frame[2]}
								<= {3'h4, OP_READ_REG, 8'h09, 8'h5f};
							5'd13: {nbytes, frame[0], frame[1], frame[2]}
								<= {3'h4, OP_READ_REG, 8'h00, 8'h00};
							5'd14: frame[1] <= STBY_RC;
							default: seq <= H_IDLE;
							endcase
						JOB_OVR_ON:
							case (step)
							5'd0: {frame[0], frame[1]} <= {OP_ROLE, ROLE_RESPONDER};
							5'd1: {frame[0], frame[1]} <= {OP_OVERHEAR, OVERHEAR_ON};
							default: seq <= H_IDLE;
							endcase
						JOB_OVR_OFF:
							case (step)
							5'd0: frame[1] <= STBY_RC;
							5'd1: {frame[0], frame[1]} <= {OP_OVERHEAR, OVERHEAR_OFF};
							default: seq <= H_IDLE;
							endcase
						JOB_REGULATOR:
							if (step == 5'd0 && uart_sel)
								{nbytes, frame[0], frame[1], frame[2]}
									<= {3'h3, OP_REGULATOR, UART_FILL, arg};
							else if (step == 5'd0)
								{frame[0], frame[1]} <= {OP_REGULATOR, arg};
							else
								seq <= H_IDLE;
						JOB_SAVE_SLEEP:
							case (step)
							5'd0: {nbytes, frame[0]} <= {3'h1, OP_SAVE_CTX};
							5'd1: {frame[0], frame[1]} <= {OP_SLEEP, SLEEP_KEEP_RAM};
							default: seq <= H_IDLE;
							endcase
						JOB_WAKE:
							if (step == 5'd0)
								{nbytes, frame[0]} <= {3'h1, OP_WAKE};
							else
								seq <= H_IDLE;
						default: seq <= H_IDLE;
						endcase
					end
				H_SEND:
				begin
					bidx <= bidx + 3'h1;
					if (bidx + 3'h1 == nbytes)
						seq <= H_READ;
				end
				H_READ:
					if (link.rsp_valid)
					begin
						last_rd <= link.rsp_byte;
						case (step)
						5'd5: result[23:16] <= link.rsp_byte;
						5'd6: result[15:8] <= link.rsp_byte;
						5'd7: result[7:0] <= link.rsp_byte;
						5'd9: addr_word[7:0] <= link.rsp_byte;
						5'd10: addr_word[15:8] <= link.rsp_byte;
						5'd12: addr_word[23:16] <= link.rsp_byte;
						5'd13: addr_word[31:24] <= link.rsp_byte;
						5'd14: rssi <= link.rsp_byte;
						default: last_rd <= link.rsp_byte;
						endcase
						seq <= H_WAIT;
					end
					else if (frame[0] != OP_READ_REG)
						seq <= H_WAIT;
				default: seq <= H_IDLE;
			endcase
		end
	end

	assign link.cmd_valid = (seq == H_SEND);
	assign link.cmd_byte = frame[bidx];
	assign link.cmd_last = (seq == H_SEND) && (bidx + 3'h1 == nbytes);
endmodule

//--- design/rrc_link_if.sv
// Interface joining the host controller and the device command end.
// Bytes pass one a cycle under a valid flag; frames end with last.
interface rrc_link_if (
	input wire logic core_clk, // Shared clock.
	input wire logic rst // Shared reset.
);
	logic cmd_valid;
	logic [7:0] cmd_byte;
	logic cmd_last;
	logic uart_mode;
	logic rsp_valid;
	logic [7:0] rsp_byte;
	logic busy;
	logic [15:0] irq;
	logic ranging_start;
	logic ranging_fail;
	modport host (input core_clk, rst, rsp_valid, rsp_byte, busy, irq,
		ranging_fail, output cmd_valid, cmd_byte, cmd_last, uart_mode,
		ranging_start);
	modport dev (input core_clk, rst, cmd_valid, cmd_byte, cmd_last,
		uart_mode, ranging_start, output rsp_valid, rsp_byte, busy, irq,
		ranging_fail);
endinterface

//--- design/rrc_pkg.sv
// Package for the ranging readout and miscellaneous command block.
// Assumes both ends share one clock and reset.
package rrc_pkg;
	// ==========================================================
	// Command opcodes and parameter values
	localparam logic [7:0] OP_ROLE = 8'ha3;
	localparam logic [7:0] OP_OVERHEAR = 8'h9a;
	localparam logic [7:0] OP_REGULATOR = 8'h96;
	localparam logic [7:0] OP_SAVE_CTX = 8'hd5;
	localparam logic [7:0] OP_SLEEP = 8'h84;
	localparam logic [7:0] OP_STANDBY = 8'h80;
	localparam logic [7:0] OP_WRITE_REG = 8'h18;
	localparam logic [7:0] OP_READ_REG = 8'h19;
	localparam logic [7:0] OP_WAKE = 8'hc0;
	localparam logic [7:0] UART_FILL = 8'h01;
	localparam logic [7:0] ROLE_RESPONDER = 8'h00;
	localparam logic [7:0] OVERHEAR_ON = 8'h01;
	localparam logic [7:0] OVERHEAR_OFF = 8'h00;
	localparam logic [7:0] STBY_RC = 8'h00;
	localparam logic [7:0] STBY_XOSC = 8'h01;
	localparam logic [7:0] SLEEP_KEEP_RAM = 8'h01;
	// ==========================================================
	// Device register map
	localparam logic [11:0] REG_OUT_SEL = 12'h924;
	localparam logic [11:0] REG_ADDR_SEL = 12'h927;
	localparam logic [11:0] REG_ADDR_ODD = 12'h95f;
	localparam logic [11:0] REG_ADDR_EVEN = 12'h960;
	localparam logic [11:0] REG_RES_HIGH = 12'h961;
	localparam logic [11:0] REG_RES_MID = 12'h962;
	localparam logic [11:0] REG_RES_LOW = 12'h963;
	localparam logic [11:0] REG_MEM_CLK = 12'h97f;
	localparam logic [7:0] MASK_KIND = 8'hcf;
	localparam logic [7:0] MASK_ASEL = 8'hfc;
	localparam logic [1:0] KIND_FIELD = 2'h3;
	localparam int KIND_LSB = 4;
	localparam int MEM_CLK_BIT = 1;
	localparam logic [15:0] IRQ_EXCH_DONE = 16'h8000;
	localparam logic [7:0] RX_PTR_RESET = 8'h00;
	// ==========================================================
	// Host AHB-Lite register offsets
	localparam logic [7:0] HA_CMD = 8'h00;
	localparam logic [7:0] HA_ARG = 8'h04;
	localparam logic [7:0] HA_STATUS = 8'h08;
	localparam logic [7:0] HA_RESULT = 8'h0c;
	localparam logic [7:0] HA_ADDR = 8'h10;
	localparam logic [7:0] HA_RSSI = 8'h14;
	localparam logic [2:0] JOB_READ = 3'h1;
	localparam logic [2:0] JOB_OVR_ON = 3'h2;
	localparam logic [2:0] JOB_OVR_OFF = 3'h3;
	localparam logic [2:0] JOB_REGULATOR = 3'h4;
	localparam logic [2:0] JOB_SAVE_SLEEP = 3'h5;
	localparam logic [2:0] JOB_WAKE = 3'h6;
	localparam logic [3:0] MAX_ERRORS = 4'h3;
endpackage

//--- tb/rrc_link_properties.sv
// Concurrent checks on the command link between the host and device ends.
// Assumes the bench top feeds the link signals in directly.
module rrc_link_properties
	import rrc_pkg::*;
(
	input wire logic core_clk, // Shared clock.
	input wire logic rst, // Shared reset.
	input wire logic cmd_valid, // Command byte valid.
	input wire logic [7:0] cmd_byte, // Command byte.
	input wire logic cmd_last, // Last byte of frame.
	input wire logic uart_mode, // Framing mode.
	input wire logic rsp_valid, // Read answer valid.
	input wire logic [7:0] rsp_byte, // Read answer byte.
	input wire logic busy, // Device decoder busy.
	input wire logic [15:0] irq, // Device interrupt flags.
	input wire logic ranging_start, // Ranging start request.
	input wire logic ranging_fail // Ranging failure pulse.
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Frame tracking
	logic in_frame;
	logic [2:0] idx;
	logic [7:0] op_q;
	logic [7:0] p1_q;
	logic xosc;
	logic role_resp;
	wire logic first = cmd_valid && !in_frame;
	wire logic param = cmd_valid && in_frame && idx == 3'h1;
	wire logic [11:0] rd_addr = {p1_q[3:0], cmd_byte};

	// Byte position, opcode and first parameter of the frame in flight.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			in_frame <= 1'b0;
			idx <= 3'h0;
			op_q <= 8'h00;
			p1_q <= 8'h00;
		end
		else if (cmd_valid)
		begin
			in_frame <= !cmd_last;
			idx <= in_frame ? idx + 3'h1 : 3'h1;
			if (!in_frame)
				op_q <= cmd_byte;
			if (param)
				p1_q <= cmd_byte;
		end
	end

	// Standby and role last commanded, as the device should see them.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			xosc <= 1'b0;
			role_resp <= 1'b0;
		end
		else
		begin
			if (param && op_q == OP_STANDBY)
				xosc <= (cmd_byte == STBY_XOSC);
			if (param && op_q == OP_ROLE)
				role_resp <= (cmd_byte == ROLE_RESPONDER);
		end
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_read_end;
		cmd_valid && cmd_last && in_frame && op_q == OP_READ_REG;
	endsequence

	sequence s_param_last;
		cmd_valid && cmd_last;
	endsequence

	sequence s_uart_fill;
		cmd_valid && cmd_byte == UART_FILL && !cmd_last;
	endsequence

	a_uart_fill_byte: assert property (
		first && cmd_byte == OP_REGULATOR && uart_mode |->
		!cmd_last ##1 s_uart_fill ##1 s_param_last)
		else $error("UART regulator frame lacks its fill byte");
	a_reg_one_param: assert property (
		first && cmd_byte == OP_REGULATOR && !uart_mode |->
		!cmd_last ##1 s_param_last)
		else $error("regulator frame not two bytes");
	a_save_single_byte: assert property (
		first && cmd_byte == OP_SAVE_CTX |-> cmd_last)
		else $error("save context frame longer than one byte");
	a_read_answer: assert property (
		s_read_end |=> rsp_valid) else $error("read answer missing");
	a_rsp_cause: assert property (
		rsp_valid |-> $past(cmd_valid && cmd_last && op_q == OP_READ_REG))
		else $error("read answer without read frame");
	a_result_in_xosc: assert property (
		cmd_valid && in_frame && idx == 3'h2 && op_q == OP_READ_REG &&
		rd_addr >= REG_RES_HIGH && rd_addr <= REG_RES_LOW |-> xosc)
		else $error("result read outside crystal standby");
	a_on_after_role: assert property (
		param && op_q == OP_OVERHEAR && cmd_byte == OVERHEAR_ON |-> role_resp)
		else $error("overhear enabled without responder role");
	a_off_in_rc: assert property (
		param && op_q == OP_OVERHEAR && cmd_byte == OVERHEAR_OFF |-> !xosc)
		else $error("overhear disabled outside RC standby");
	a_irq_holds: assert property (
		irq[15] && !cmd_valid && !$past(cmd_valid) |=> irq[15])
		else $error("exchange done flag dropped early");
	c_exch_done: cover property ($rose(irq[15]));
endmodule

//--- tb/tb_ranging_readout_and_misc_cmds.sv
// Bench top: software over AHB-Lite drives the host end across the link.
// Assumes zero-wait AHB slave and device measurement inputs as levels.
module tb_ranging_readout_and_misc_cmds
	import rrc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [23:0] meas_result = 24'h5a3c81;
	logic [23:0] meas_filtered = 24'h13f0a6;
	logic [7:0] meas_rssi = 8'h2d;
	logic [31:0] heard_addr = 32'h8c4e1a73;
	logic response_heard = 1'b0;
	logic switcher_on;
	logic overhear_active;
	logic asleep;
	logic [7:0] rx_payload_ptr;
	logic [31:0] rd;
	int err_total = 0;
	int checks_done = 0;
	int cycles = 0;

	rrc_link_if rrc_link_if_inst (.core_clk(core_clk), .rst(rst));
	rrc_host rrc_host_inst (.hclk(core_clk), .hresetn(!rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .link(rrc_link_if_inst));
	rrc_dev rrc_dev_inst (.link(rrc_link_if_inst), .meas_result(meas_result),
		.meas_filtered(meas_filtered), .meas_rssi(meas_rssi),
		.heard_addr(heard_addr), .response_heard(response_heard),
		.duty_cycle(1'b0), .switcher_on(switcher_on),
		.overhear_active(overhear_active), .asleep(asleep),
		.rx_payload_ptr(rx_payload_ptr));
	rrc_link_properties rrc_link_properties_inst (.core_clk(core_clk),
		.rst(rst), .cmd_valid(rrc_link_if_inst.cmd_valid),
		.cmd_byte(rrc_link_if_inst.cmd_byte),
		.cmd_last(rrc_link_if_inst.cmd_last),
		.uart_mode(rrc_link_if_inst.uart_mode),
		.rsp_valid(rrc_link_if_inst.rsp_valid),
		.rsp_byte(rrc_link_if_inst.rsp_byte), .busy(rrc_link_if_inst.busy),
		.irq(rrc_link_if_inst.irq),
		.ranging_start(rrc_link_if_inst.ranging_start),
		.ranging_fail(rrc_link_if_inst.ranging_fail));

	// ==========================================================
	// Clock, timeout and reporting
	initial
	begin
		forever #12.5 core_clk = !core_clk;
	end

	// Cuts a hung run short well beyond the fewer than two thousand cycles needed.
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_total = err_total + 1;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp)
		begin
			err_total = err_total + 1;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// ==========================================================
	// AHB-Lite single word transfer; phases held until hready is high.
	task automatic ahb(input logic [7:0] a, input logic w,
		input logic [31:0] wd, output logic [31:0] r);
		logic ok;
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= 3'h2;
		do
		begin
			@(negedge core_clk);
			ok = hreadyout;
			@(posedge core_clk);
		end while (ok !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do
		begin
			@(negedge core_clk);
			ok = hreadyout;
			r = hrdata;
			@(posedge core_clk);
		end while (ok !== 1'b1);
	endtask

	// Starts a job and polls status until the sequencer goes idle.
	task automatic run_job(input logic [2:0] job, input logic [31:0] arg);
		int n;
		ahb(HA_ARG, 1'b1, arg, rd);
		ahb(HA_CMD, 1'b1, {29'h0, job}, rd);
		n = 0;
		do
		begin
			ahb(HA_STATUS, 1'b0, 32'h0, rd);
			n = n + 1;
		end while (rd[2] !== 1'b0 && n < 300);
		chk("job idle", rd[2], 1'b0);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk("switcher after reset", switcher_on, 1'b0);
		chk("overhear after reset", overhear_active, 1'b0);
		ahb(8'h1c, 1'b1, 32'hffffffff, rd);
		ahb(HA_STATUS, 1'b0, 32'h0, rd);
		chk("status after unmapped write", rd[2], 1'b0);
	endtask

	// One heard response first, so the result registers hold a capture.
	task automatic t_readout();
		@(posedge core_clk);
		response_heard <= 1'b1;
		@(posedge core_clk);
		response_heard <= 1'b0;
		run_job(JOB_READ, 32'h0);
		ahb(HA_RESULT, 1'b0, 32'h0, rd);
		chk("raw result", rd[23:0], meas_result);
		ahb(HA_ADDR, 1'b0, 32'h0, rd);
		chk("heard address", rd, heard_addr);
		ahb(HA_RSSI, 1'b0, 32'h0, rd);
		chk("signal strength", rd[7:0], meas_rssi);
		run_job(JOB_READ, 32'h1);
		ahb(HA_RESULT, 1'b0, 32'h0, rd);
		chk("filtered result", rd[23:0], meas_filtered);
	endtask

	task automatic t_overhear();
		run_job(JOB_OVR_ON, 32'h0);
		chk("overhear on", overhear_active, 1'b1);
		@(posedge core_clk);
		response_heard <= 1'b1;
		@(posedge core_clk);
		response_heard <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk("exchange done", rrc_link_if_inst.irq[15], 1'b1);
		run_job(JOB_OVR_OFF, 32'h0);
		chk("overhear off", overhear_active, 1'b0);
	endtask

	// The switcher may run only while a read job holds crystal standby.
	// Bit 8 of the mode asks the host for UART framing of the command.
	task automatic t_regulator(input logic [31:0] mode);
		logic seen;
		seen = 1'b0;
		run_job(JOB_REGULATOR, mode);
		fork
			run_job(JOB_READ, 32'h0);
			repeat (400)
			begin
				@(negedge core_clk);
				seen = seen | (switcher_on === 1'b1);
			end
		join
		chk("switcher in crystal standby", seen, mode[0]);
		chk("switcher in RC standby", switcher_on, 1'b0);
	endtask

	task automatic t_sleep();
		run_job(JOB_SAVE_SLEEP, 32'h0);
		chk("asleep", asleep, 1'b1);
		run_job(JOB_WAKE, 32'h0);
		chk("awake", asleep, 1'b0);
		chk("payload pointer", rx_payload_ptr, RX_PTR_RESET);
	endtask

	// Main sequence: reset for 16 cycles, then each scenario in turn.
	initial
	begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_reset();
		t_readout();
		t_overhear();
		t_regulator(32'h1);
		t_regulator(32'h0);
		t_regulator(32'h101);
		t_sleep();
		finish_test();
	end
endmodule
